/* gh_cmd_top.v */
// I2C command interpreter for a gas plus humidity/temperature sensor module
`timescale 1ns/1ps
`include "gh_defs.vh"
// How it works
// - Start 0x2003, no data, 10 ms busy
// - Measure 0x2008, six bytes, 12 ms max
// - Baseline read 0x2015, write 0x201e, 10 ms
// - Humidity input 0x2061, three bytes, 10 ms
// - Self-test 0x2032, three bytes, 220 ms
// - Version 0x202f 2 ms; raw 0x2050 25 ms
// - Start command launches measurement and baseline tracking
// - Measure returns carbon then organic, CRC each
// - First 15 s return 400 and 0
// - Baseline read returns carbon then organic words
// - Raw returns hydrogen then ethanol words
// - Humidity word is unsigned 8.8 fixed point
// - Written humidity kept until next write
// - Reset or zero write loads default 0x0b92
// - Version word: type high, version low bits
// - Passing self-test returns 0xd400 with CRC
// - Self-test ends with gas part asleep
// - General call 0x00 then 0x06 resets
// - While busy, both part addresses get NACK; general call still ACKed
// - CRC-8 poly 0x31, init 0xff, plain
// - Parameter word with bad CRC is discarded
module gh_cmd_top #(
    parameter [31:0] CYC_MS = `GH_CYC_PER_MS,
    parameter [31:0] T_WARMUP = `GH_WARMUP_S * 1000 * `GH_CYC_PER_MS,
    // Arbitrary feature set word
    parameter [15:0] FEATURE_SET = 16'h0042
) (
    // Clock and reset
    input wire CLK,
    input wire RESET_N,
    // I2C pins
    input wire SCL,
    input wire SDA_IN,
    output wire SDA_OUT,
    output wire SDA_OE,
    // Sensing front end values
    input wire [15:0] CARBON_EQUIVALENT_LEVEL,
    input wire [15:0] TOTAL_ORGANIC_LEVEL,
    input wire [15:0] BASE_CARBON_IN,
    input wire [15:0] BASE_ORGANIC_IN,
    input wire [15:0] HYDROGEN_RAW_VALUE,
    input wire [15:0] ETHANOL_RAW_VALUE,
    input wire [15:0] TEMPERATURE_VALUE,
    input wire [15:0] HUMIDITY_VALUE,
    input wire SELF_TEST_OK,
    // Front end control
    output wire AQ_START,
    output wire AQ_ACTIVE,
    output wire AQ_WARMUP,
    output wire MEAS_BUSY,
    output wire BASE_WRITE,
    output wire [15:0] BASE_CARBON_OUT,
    output wire [15:0] BASE_ORGANIC_OUT,
    output wire [15:0] HUM_COMP
);

    // ********************
    // Local codes
    // ********************
    localparam [2:0] ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_WRITE = 3'h2;
    localparam [2:0] ST_READ = 3'h3, ST_IGNORE = 3'h4;
    localparam [3:0] OP_INIT = 4'h0, OP_MEAS = 4'h1, OP_GETB = 4'h2, OP_SETB = 4'h3;
    localparam [3:0] OP_HUM = 4'h4, OP_TEST = 4'h5, OP_VER = 4'h6, OP_RAW = 4'h7;
    localparam [3:0] OP_RHT_T = 4'h8, OP_RHT_H = 4'h9;

    // ********************
    // Functions
    // ********************
    // Bitwise CRC-8 over one word
    function [7:0] crc8;
        input [15:0] d;
        integer i;
        reg [7:0] c;
        begin
            c = `GH_CRC_INIT;
            for (i = 15; i >= 0; i = i - 1) begin
                if (c[7] ^ d[i])
                    c = {c[6:0], 1'b0} ^ `GH_CRC_POLY;
                else
                    c = {c[6:0], 1'b0};
            end
            crc8 = c;
        end
    endfunction

    // Command code to {valid, op}, per addressed part
    function [4:0] decode;
        input gas;
        input [15:0] c;
        begin
            case (c)
                `GH_CMD_INIT: decode = {gas, OP_INIT};
                `GH_CMD_MEAS: decode = {gas, OP_MEAS};
                `GH_CMD_GETB: decode = {gas, OP_GETB};
                `GH_CMD_SETB: decode = {gas, OP_SETB};
                `GH_CMD_HUM: decode = {gas, OP_HUM};
                `GH_CMD_TEST: decode = {gas, OP_TEST};
                `GH_CMD_VER: decode = {gas, OP_VER};
                `GH_CMD_RAW: decode = {gas, OP_RAW};
                `GH_CMD_RHT_T: decode = {~gas, OP_RHT_T};
                `GH_CMD_RHT_H: decode = {~gas, OP_RHT_H};
                default: decode = 5'h00;
            endcase
        end
    endfunction

    // Execution time of each operation in ms
    function [31:0] op_time;
        input [3:0] op;
        begin
            case (op)
                OP_INIT: op_time = `GH_T_INIT_MS;
                OP_MEAS: op_time = `GH_T_MEAS_MS;
                OP_GETB, OP_SETB: op_time = `GH_T_BASE_MS;
                OP_HUM: op_time = `GH_T_HUM_MS;
                OP_TEST: op_time = `GH_T_TEST_MS;
                OP_VER: op_time = `GH_T_VER_MS;
                OP_RAW: op_time = `GH_T_RAW_MS;
                default: op_time = `GH_T_RHT_MS;
            endcase
        end
    endfunction

    // Response byte: word high, word low, checksum
    function [7:0] resp_byte;
        input [2:0] i;
        input [15:0] a, b;
        input [2:0] len;
        reg [15:0] w;
        begin
            w = (i < 3'h3) ? a : b;
            if (i >= len)
                resp_byte = `GH_NO_DATA;
            else begin
                case (i)
                    3'h0, 3'h3: resp_byte = w[15:8];
                    3'h1, 3'h4: resp_byte = w[7:0];
                    default: resp_byte = crc8(w);
                endcase
            end
        end
    endfunction

    // ********************
    // Pin synchronisers
    // ********************
    reg [2:0] scl_reg;
    reg [2:0] sda_reg;

    // Two stages, third only for edge finding
    always @(posedge CLK) begin
        if (!RESET_N) begin
            scl_reg <= 3'h7;
            sda_reg <= 3'h7;
        end else begin
            scl_reg <= {scl_reg[1:0], SCL};
            sda_reg <= {sda_reg[1:0], SDA_IN};
        end
    end

    wire scl_rise = scl_reg[1] & ~scl_reg[2];
    wire scl_fall = ~scl_reg[1] & scl_reg[2];
    wire scl_high = scl_reg[1] & scl_reg[2];
    wire bus_start = scl_high & ~sda_reg[1] & sda_reg[2];
    wire bus_stop = scl_high & sda_reg[1] & ~sda_reg[2];

    // ********************
    // State
    // ********************
    reg [2:0] st_reg, idx_reg, len_reg;
    reg [3:0] bit_cnt_reg, op_reg;
    reg [7:0] shift_reg, tx_reg, cmd_hi_reg, p_hi_reg, p_lo_reg;
    reg sda_oe_reg, gas_reg, gcall_reg, mack_reg, rd_hit_reg, consumed_reg;
    reg busy_reg, busy_gas_reg, resp_gas_reg, aq_start_reg, aq_active_reg, base_wr_reg;
    reg [31:0] busy_cnt_reg, warm_cnt_reg;
    reg [15:0] param_organic_reg, w0_reg, w1_reg, base_carbon_reg, base_organic_reg, hum_reg;

    // Decodes shared by the sequencer
    wire [4:0] dec = decode(gas_reg, {cmd_hi_reg, shift_reg});
    wire param_op = (dec[3:0] == OP_SETB) || (dec[3:0] == OP_HUM);
    wire crc_ok = (crc8({p_hi_reg, p_lo_reg}) == shift_reg);
    wire [15:0] param_word = {p_hi_reg, p_lo_reg};
    wire [7:0] rd_byte = rd_hit_reg ? resp_byte(idx_reg, w0_reg, w1_reg, len_reg) : `GH_NO_DATA;
    wire warm = (warm_cnt_reg != 32'h0);

    // Launch an execution, dropping any unread answer
    task start_busy;
        input [3:0] op;
        begin
            busy_reg <= 1'b1;
            busy_gas_reg <= gas_reg;
            busy_cnt_reg <= op_time(op) * CYC_MS;
            len_reg <= `GH_LEN_NONE;
        end
    endtask

    // ********************
    // Bus sequencer and command execution
    // ********************
    always @(posedge CLK) begin
        if (!RESET_N) begin
            st_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            idx_reg <= 3'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            sda_oe_reg <= 1'b0;
            gas_reg <= 1'b0;
            gcall_reg <= 1'b0;
            mack_reg <= 1'b0;
            rd_hit_reg <= 1'b0;
            consumed_reg <= 1'b0;
            cmd_hi_reg <= 8'h00;
            op_reg <= 4'h0;
            p_hi_reg <= 8'h00;
            p_lo_reg <= 8'h00;
            param_organic_reg <= 16'h0000;
            busy_reg <= 1'b0;
            busy_gas_reg <= 1'b0;
            busy_cnt_reg <= 32'h0;
            warm_cnt_reg <= 32'h0;
            w0_reg <= 16'h0000;
            w1_reg <= 16'h0000;
            len_reg <= `GH_LEN_NONE;
            resp_gas_reg <= 1'b0;
            aq_start_reg <= 1'b0;
            aq_active_reg <= 1'b0;
            base_wr_reg <= 1'b0;
            base_carbon_reg <= 16'h0000;
            base_organic_reg <= 16'h0000;
            hum_reg <= `GH_HUM_DEFAULT;
        end else begin
            aq_start_reg <= 1'b0;
            base_wr_reg <= 1'b0;
            if (warm)
                warm_cnt_reg <= warm_cnt_reg - 32'h1;
            // Execution end loads the answer
            if (busy_reg) begin
                if (busy_cnt_reg <= 32'h1) begin
                    busy_reg <= 1'b0;
                    resp_gas_reg <= busy_gas_reg;
                    len_reg <= `GH_LEN_TWO;
                    case (op_reg)
                        OP_MEAS: begin
                            w0_reg <= warm ? `GH_CO2_WARM : CARBON_EQUIVALENT_LEVEL;
                            w1_reg <= warm ? `GH_TOTAL_ORGANIC_LEVEL_WARM : TOTAL_ORGANIC_LEVEL;
                        end
                        OP_GETB: begin
                            w0_reg <= BASE_CARBON_IN;
                            w1_reg <= BASE_ORGANIC_IN;
                        end
                        OP_RAW: begin
                            w0_reg <= HYDROGEN_RAW_VALUE;
                            w1_reg <= ETHANOL_RAW_VALUE;
                        end
                        OP_RHT_T: begin
                            w0_reg <= TEMPERATURE_VALUE;
                            w1_reg <= HUMIDITY_VALUE;
                        end
                        OP_RHT_H: begin
                            w0_reg <= HUMIDITY_VALUE;
                            w1_reg <= TEMPERATURE_VALUE;
                        end
                        OP_TEST: begin
                            w0_reg <= SELF_TEST_OK ? `GH_TEST_PASS : `GH_TEST_FAIL;
                            len_reg <= `GH_LEN_ONE;
                            aq_active_reg <= 1'b0;
                            warm_cnt_reg <= 32'h0;
                        end
                        OP_VER: begin
                            w0_reg <= FEATURE_SET;
                            len_reg <= `GH_LEN_ONE;
                        end
                        default: len_reg <= `GH_LEN_NONE;
                    endcase
                end else begin
                    busy_cnt_reg <= busy_cnt_reg - 32'h1;
                end
            end
            // Bus conditions and bit slots
            if (bus_start || bus_stop) begin
                st_reg <= bus_start ? ST_ADDR : ST_IDLE;
                bit_cnt_reg <= 4'h0;
                idx_reg <= 3'h0;
                sda_oe_reg <= 1'b0;
                consumed_reg <= 1'b0;
                if (consumed_reg)
                    len_reg <= `GH_LEN_NONE;
            end else if (scl_rise) begin
                if (bit_cnt_reg == 4'h8) begin
                    bit_cnt_reg <= 4'h0;
                    mack_reg <= ~sda_reg[1];
                end else begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    shift_reg <= {shift_reg[6:0], sda_reg[1]};
                end
            end else if (scl_fall) begin
                case (st_reg)
                    ST_ADDR: begin
                        if (bit_cnt_reg == 4'h8) begin
                            idx_reg <= 3'h0;
                            gcall_reg <= (shift_reg[7:1] == `GH_ADDR_GCALL);
                            gas_reg <= (shift_reg[7:1] == `GH_ADDR_GAS);
                            if (shift_reg == {`GH_ADDR_GCALL, 1'b0}) begin
                                st_reg <= ST_WRITE;
                                sda_oe_reg <= 1'b1;
                            end else if (((shift_reg[7:1] == `GH_ADDR_GAS) ||
                                    (shift_reg[7:1] == `GH_ADDR_RHT)) && !busy_reg) begin
                                st_reg <= shift_reg[0] ? ST_READ : ST_WRITE;
                                sda_oe_reg <= 1'b1;
                                mack_reg <= 1'b1;
                                rd_hit_reg <= (len_reg != `GH_LEN_NONE) &&
                                    (resp_gas_reg == (shift_reg[7:1] == `GH_ADDR_GAS));
                            end else begin
                                st_reg <= ST_IGNORE;
                            end
                        end
                    end
                    ST_WRITE: begin
                        if (bit_cnt_reg == 4'h8) begin
                            sda_oe_reg <= 1'b1;
                            if (idx_reg != 3'h7)
                                idx_reg <= idx_reg + 3'h1;
                            if (gcall_reg) begin
                                if (idx_reg == 3'h0 && shift_reg == `GH_GCALL_RESET) begin
                                    aq_active_reg <= 1'b0;
                                    warm_cnt_reg <= 32'h0;
                                    hum_reg <= `GH_HUM_DEFAULT;
                                    if (busy_gas_reg)
                                        busy_reg <= 1'b0;
                                    if (resp_gas_reg)
                                        len_reg <= `GH_LEN_NONE;
                                end
                            end else begin
                                case (idx_reg)
                                    3'h0: cmd_hi_reg <= shift_reg;
                                    3'h1: begin
                                        if (dec[4]) begin
                                            op_reg <= dec[3:0];
                                            if (!param_op)
                                                start_busy(dec[3:0]);
                                            if (dec[3:0] == OP_INIT) begin
                                                aq_start_reg <= 1'b1;
                                                aq_active_reg <= 1'b1;
                                                warm_cnt_reg <= T_WARMUP;
                                            end
                                        end else begin
                                            sda_oe_reg <= 1'b0;
                                            st_reg <= ST_IGNORE;
                                        end
                                    end
                                    3'h2, 3'h5: p_hi_reg <= shift_reg;
                                    3'h3, 3'h6: p_lo_reg <= shift_reg;
                                    default: begin
                                        if (!crc_ok || idx_reg == 3'h7 && op_reg != OP_SETB ||
                                                !(op_reg == OP_SETB || op_reg == OP_HUM)) begin
                                            sda_oe_reg <= 1'b0;
                                            st_reg <= ST_IGNORE;
                                        end else if (op_reg == OP_HUM) begin
                                            // Zero selects the default
                                            hum_reg <= (param_word == `GH_HUM_OFF) ?
                                                `GH_HUM_DEFAULT : param_word;
                                            start_busy(OP_HUM);
                                        end else if (idx_reg == 3'h4) begin
                                            param_organic_reg <= param_word;
                                        end else begin
                                            base_organic_reg <= param_organic_reg;
                                            base_carbon_reg <= param_word;
                                            base_wr_reg <= 1'b1;
                                            start_busy(OP_SETB);
                                        end
                                    end
                                endcase
                            end
                        end else if (bit_cnt_reg == 4'h0) begin
                            sda_oe_reg <= 1'b0;
                        end
                    end
                    ST_READ: begin
                        if (bit_cnt_reg == 4'h0) begin
                            if (mack_reg) begin
                                tx_reg <= rd_byte;
                                sda_oe_reg <= ~rd_byte[7];
                                consumed_reg <= rd_hit_reg;
                                if (idx_reg != 3'h7)
                                    idx_reg <= idx_reg + 3'h1;
                            end else begin
                                sda_oe_reg <= 1'b0;
                                st_reg <= ST_IGNORE;
                            end
                        end else if (bit_cnt_reg == 4'h8) begin
                            sda_oe_reg <= 1'b0;
                        end else begin
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            sda_oe_reg <= ~tx_reg[6];
                        end
                    end
                    default: sda_oe_reg <= 1'b0;
                endcase
            end
        end
    end

    // ********************
    // Outputs
    // ********************
    assign SDA_OUT = 1'b0;
    assign SDA_OE = sda_oe_reg;
    assign AQ_START = aq_start_reg;
    assign AQ_ACTIVE = aq_active_reg;
    assign AQ_WARMUP = warm;
    assign MEAS_BUSY = busy_reg;
    assign BASE_WRITE = base_wr_reg;
    assign BASE_CARBON_OUT = base_carbon_reg;
    assign BASE_ORGANIC_OUT = base_organic_reg;
    assign HUM_COMP = hum_reg;

endmodule

/* gh_defs.vh */
// Constants for the gas and humidity sensor command interpreter
`ifndef GH_DEFS_VH
`define GH_DEFS_VH

// ********************
// Bus addresses
// ********************
`define GH_ADDR_GAS 7'h58
`define GH_ADDR_RHT 7'h70
`define GH_ADDR_GCALL 7'h00
`define GH_GCALL_RESET 8'h06

// ********************
// Command codes
// ********************
`define GH_CMD_INIT 16'h2003
`define GH_CMD_MEAS 16'h2008
`define GH_CMD_GETB 16'h2015
`define GH_CMD_SETB 16'h201e
`define GH_CMD_HUM 16'h2061
`define GH_CMD_TEST 16'h2032
`define GH_CMD_VER 16'h202f
`define GH_CMD_RAW 16'h2050
`define GH_CMD_RHT_T 16'h7866
`define GH_CMD_RHT_H 16'h58e0

// ********************
// Checksum and fixed values
// ********************
`define GH_CRC_POLY 8'h31
`define GH_CRC_INIT 8'hff
`define GH_HUM_DEFAULT 16'h0b92
`define GH_HUM_OFF 16'h0000
`define GH_CO2_WARM 16'h0190
`define GH_TOTAL_ORGANIC_LEVEL_WARM 16'h0000
`define GH_TEST_PASS 16'hd400
`define GH_TEST_FAIL 16'h0000
`define GH_NO_DATA 8'hff
`define GH_LEN_TWO 3'h6
`define GH_LEN_ONE 3'h3
`define GH_LEN_NONE 3'h0

// ********************
// Timing
// ********************
`define GH_CLK_HZ 50000000
`define GH_CYC_PER_MS (`GH_CLK_HZ / 1000)
`define GH_T_INIT_MS 10
`define GH_T_MEAS_MS 12
`define GH_T_BASE_MS 10
`define GH_T_HUM_MS 10
`define GH_T_TEST_MS 220
`define GH_T_VER_MS 2
`define GH_T_RAW_MS 25
`define GH_T_RHT_MS 15
`define GH_WARMUP_S 15

`endif

/* gh_cmd_checker.sv */
// Port checker for the sensor command interpreter
`timescale 1ns/1ps
module gh_cmd_checker (
    // Clock and reset
    input wire CLK,
    input wire RESET_N,
    // Watched outputs
    input wire SDA_OE,
    input wire AQ_START,
    input wire AQ_ACTIVE,
    input wire AQ_WARMUP,
    input wire MEAS_BUSY,
    input wire BASE_WRITE,
    input wire [15:0] BASE_CARBON_OUT,
    input wire [15:0] HUM_COMP
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // Command start and execution
    property p_start_busy; AQ_START |-> ##[0:2] MEAS_BUSY; endproperty
    a_start_busy: assert property (p_start_busy) else $error("start not busy");
    property p_start_act; $rose(AQ_ACTIVE) |-> AQ_START || $past(AQ_START); endproperty
    a_start_act: assert property (p_start_act) else $error("active w/o start");
    property p_warm; AQ_START |-> ##[0:2] AQ_WARMUP; endproperty
    a_warm: assert property (p_warm) else $error("no warm-up");
    property p_busy_len; $rose(MEAS_BUSY) |=> MEAS_BUSY [*8]; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too short");
    property p_busy_nack; MEAS_BUSY && $past(MEAS_BUSY, 16) |-> !SDA_OE; endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("ack while busy");
    property p_sleep; $fell(AQ_ACTIVE) |-> ##[0:1] !AQ_WARMUP; endproperty
    a_sleep: assert property (p_sleep) else $error("warm-up left on");
    property p_base_only; $changed(BASE_CARBON_OUT) |-> BASE_WRITE; endproperty
    a_base_only: assert property (p_base_only) else $error("stray baseline");
    property p_hum_rst; $rose(RESET_N) |-> HUM_COMP == 16'h0b92; endproperty
    a_hum_rst: assert property (p_hum_rst) else $error("bad humidity reset");
    // Main scenarios reached
    c_start: cover property (AQ_START);
    c_base: cover property (BASE_WRITE);
    c_sleep: cover property ($fell(AQ_ACTIVE));
endmodule

/* gh_master.sv */
// Two-wire bus master model facing the sensor
`timescale 1ns/1ps
module gh_master (
    // Link lines
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // Idle bus: clock stands high, data released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Start: data falls while clock high
    task automatic start;
        sda_low = 1'b1;
        #40 scl = 1'b0;
        #20;
    endtask
    // Stop: data rises while clock high
    task automatic stop;
        sda_low = 1'b1;
        #80 scl = 1'b1;
        #40 sda_low = 1'b0;
        #80;
    endtask
    // Eight bits and acknowledge; data only moves while clock low
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                        output logic ack);
        logic [8:0] bits, got;
        bits = {tx, ~mack};
        for (int i = 8; i >= 0; i--) begin
            sda_low = ~bits[i];
            #80 scl = 1'b1;
            #30 got[i] = sda;
            #30 scl = 1'b0;
            #20;
        end
        rx = got[8:1];
        ack = ~got[0];
    endtask
endmodule

/* tb_gas_humidity_sensor_commands.sv */
// Testbench for the sensor command interpreter
`timescale 1ns/1ps
module tb_gas_humidity_sensor_commands;
    logic clk = 1'b0, reset_n = 1'b0, ok = 1'b0;
    logic [15:0] fe [0:7] = '{default: 16'h0};
    wire scl, sda_low, sda_out, sda_oe, active, warm, busy;
    wire sda = ~(sda_low | sda_oe & ~sda_out);
    wire [15:0] bc, bo, hum;
    int mismatches = 0, comparisons = 0, cyc = 0;
    gh_master m (.scl(scl), .sda_low(sda_low), .sda(sda));
    // 20 cycles per ms
    gh_cmd_top #(.CYC_MS(20), .T_WARMUP(2000)) gh_cmd_top_inst (
        .CLK(clk), .RESET_N(reset_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .CARBON_EQUIVALENT_LEVEL(fe[0]), .TOTAL_ORGANIC_LEVEL(fe[1]), .BASE_CARBON_IN(fe[2]),
        .BASE_ORGANIC_IN(fe[3]), .HYDROGEN_RAW_VALUE(fe[4]), .ETHANOL_RAW_VALUE(fe[5]),
        .TEMPERATURE_VALUE(fe[6]), .HUMIDITY_VALUE(fe[7]), .SELF_TEST_OK(ok), .AQ_START(),
        .AQ_ACTIVE(active), .AQ_WARMUP(warm), .MEAS_BUSY(busy), .BASE_WRITE(),
        .BASE_CARBON_OUT(bc), .BASE_ORGANIC_OUT(bo), .HUM_COMP(hum));
    // Clock and hang limit
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            close_out;
        end
    end
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
        return c;
    endfunction
    // Front-end values: base plus index, off the edge
    task automatic set_fe(input logic [15:0] b, input logic t);
        @(posedge clk);
        #1 ok = t;
        for (int i = 0; i < 8; i++) fe[i] = b + 16'(i);
    endtask
    task automatic idle;
        int n = 0;
        repeat (4) @(posedge clk);
        while (busy !== 1'b0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        chk(16'(busy), 16'h0);
        #1;
    endtask
    // Write command and words, optional busy probe, then read words back
    task automatic op(input logic [6:0] a, input logic [15:0] c, input int np,
        input logic [15:0] p0, input logic [15:0] p1, input logic [7:0] cx, input int nr,
        input logic [15:0] e0, input logic [15:0] e1, input bit pb);
        logic [7:0] r, h;
        logic k;
        logic [15:0] w;
        @(posedge clk) #1;
        m.start;
        m.xfer({a, 1'b0}, 1'b0, r, k);
        m.xfer(c[15:8], 1'b0, r, k);
        m.xfer(c[7:0], 1'b0, r, k);
        chk(16'(k), 16'h1);
        for (int i = 0; i < np; i++) begin
            w = (i == 0) ? p0 : p1;
            m.xfer(w[15:8], 1'b0, r, k);
            m.xfer(w[7:0], 1'b0, r, k);
            m.xfer(crc8(w) ^ ((i == np - 1) ? cx : 8'h00), 1'b0, r, k);
            chk(16'(k), 16'(i < np - 1 || cx == 8'h00));
        end
        m.stop;
        if (pb) begin
            m.start;
            m.xfer({a, 1'b1}, 1'b0, r, k);
            chk(16'(k), 16'h0);
            m.stop;
        end
        idle;
        if (nr > 0) begin
            m.start;
            m.xfer({a, 1'b1}, 1'b0, r, k);
            chk(16'(k), 16'h1);
            for (int i = 0; i < nr; i++) begin
                m.xfer(8'hff, 1'b1, h, k);
                m.xfer(8'hff, 1'b1, r, k);
                w = {h, r};
                m.xfer(8'hff, i < nr - 1, r, k);
                chk(w, (i == 0) ? e0 : e1);
                chk(16'(r), 16'(crc8(w)));
            end
            m.stop;
        end
    endtask
    // Self-test before any start leaves the gas part asleep
    task automatic s_test;
        set_fe(16'h0300, 1'b1);
        op(7'h58, 16'h2032, 0, 0, 0, 0, 1, 16'hd400, 0, 0);
        chk(16'(active), 16'h0);
    endtask
    // Start, warm-up answers, then live answers
    task automatic s_meas;
        int n = 0;
        set_fe(16'h1200, 1'b1);
        op(7'h58, 16'h2003, 0, 0, 0, 0, 0, 0, 0, 1);
        chk(16'({active, warm}), 16'h3);
        op(7'h58, 16'h2008, 0, 0, 0, 0, 2, 16'h0190, 16'h0000, 1);
        while (warm !== 1'b0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        op(7'h58, 16'h2008, 0, 0, 0, 0, 2, 16'h1200, 16'h1201, 0);
    endtask
    // Baseline read, restore, and a restore with a bad checksum
    task automatic s_base;
        op(7'h58, 16'h2015, 0, 0, 0, 0, 2, 16'h1202, 16'h1203, 0);
        op(7'h58, 16'h201e, 2, 16'h0aa1, 16'h0bb2, 0, 0, 0, 0, 0);
        chk(bo, 16'h0aa1);
        op(7'h58, 16'h201e, 2, 16'h0123, 16'h0456, 8'h01, 0, 0, 0, 0);
        chk(bc, 16'h0bb2);
    endtask
    // Humidity input kept across raw, version and other-part reads
    task automatic s_misc;
        op(7'h58, 16'h2061, 1, 16'hffff, 0, 0, 0, 0, 0, 0);
        op(7'h58, 16'h2061, 1, 16'h0000, 0, 0, 0, 0, 0, 0);
        chk(hum, 16'h0b92);
        op(7'h58, 16'h2061, 1, 16'h0f80, 0, 0, 0, 0, 0, 0);
        op(7'h58, 16'h2050, 0, 0, 0, 0, 2, 16'h1204, 16'h1205, 0);
        op(7'h58, 16'h202f, 0, 0, 0, 0, 1, 16'h0042, 0, 0);
        op(7'h70, 16'h7866, 0, 0, 0, 0, 2, 16'h1206, 16'h1207, 0);
        op(7'h70, 16'h58e0, 0, 0, 0, 0, 2, 16'h1207, 16'h1206, 0);
        chk(hum, 16'h0f80);
    endtask
    // Unknown command refused, then general-call reset and restart
    task automatic s_reset;
        logic [7:0] r;
        logic k;
        m.start;
        m.xfer(8'hb0, 1'b0, r, k);
        m.xfer(8'h20, 1'b0, r, k);
        m.xfer(8'h99, 1'b0, r, k);
        chk(16'(k), 16'h0);
        m.stop;
        m.start;
        m.xfer(8'h00, 1'b0, r, k);
        m.xfer(8'h06, 1'b0, r, k);
        chk(16'(k), 16'h1);
        m.stop;
        repeat (4) @(posedge clk);
        chk({hum[15:1], active}, 16'h0b92);
        op(7'h58, 16'h2003, 0, 0, 0, 0, 0, 0, 0, 0);
        chk(16'(active), 16'h1);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge clk);
        s_test;
        s_meas;
        s_base;
        s_misc;
        s_reset;
        close_out;
    end
endmodule
bind gh_cmd_top gh_cmd_checker gh_cmd_checker_inst (.CLK(CLK), .RESET_N(RESET_N),
    .SDA_OE(SDA_OE), .AQ_START(AQ_START), .AQ_ACTIVE(AQ_ACTIVE), .AQ_WARMUP(AQ_WARMUP),
    .MEAS_BUSY(MEAS_BUSY), .BASE_WRITE(BASE_WRITE), .BASE_CARBON_OUT(BASE_CARBON_OUT),
    .HUM_COMP(HUM_COMP));
